// File: lgc_pkg.sv
// Constants and state types for the LED grayscale latch and PWM control block
`default_nettype none
package lgc_pkg;
  // ==========================================
  // Shift register and latch layout
  localparam int SR_W        = 257;
  localparam int SR_MSB      = 256;
  localparam int GS_W        = 256;
  localparam int CH_N        = 16;
  localparam int GS_BITS     = 16;
  localparam int CTL_W       = 120;
  localparam int CTL_KEEP_W  = 119;
  localparam int CTL_TMR_BIT = 119;
  // ==========================================
  // Synchronised pin positions
  localparam int PIN_N     = 6;
  localparam int PIN_SIN   = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_LAT   = 2;
  localparam int PIN_GRAYSCALE_CLOCK = 3;
  localparam int PIN_BLANK = 4;
  localparam int PIN_SHORT = 5;
  // ==========================================
  // Register port map and fields
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_INT_EN  = 8'h04;
  localparam logic [7:0] REG_INT_CLR = 8'h08;
  localparam logic [7:0] REG_COUNTER = 8'h0C;
  localparam logic [7:0] REG_FLAGS   = 8'h10;
  localparam int EV_W        = 3;
  localparam int EV_GS       = 0;
  localparam int EV_CTL      = 1;
  localparam int EV_SHORT    = 2;
  localparam int FLAG_SHORT  = 0;
  localparam int FLAG_TMR    = 1;
  // ==========================================
  // Reset values and last counter value
  localparam logic [EV_W-1:0]    EV_RST   = 3'h0;
  localparam logic [GS_BITS-1:0] CNT_RST  = 16'h0000;
  localparam logic [GS_BITS-1:0] CNT_LAST = 16'hFFFF;
  localparam logic [CH_N-1:0]    CHAN_RST = 16'h0000;
  // ==========================================
  // State types
  typedef struct packed {
    logic [SR_W-1:0]       shift;
    logic [GS_W-1:0]       gs1;
    logic [GS_W-1:0]       gs2;
    logic [CTL_W-1:0]      ctl1;
    logic [CTL_KEEP_W-1:0] ctl2;
    logic [EV_W-1:0]       status;
    logic [EV_W-1:0]       irq_en;
    logic                  short_flag;
    logic                  restart;
    logic [DATA_W-1:0]     rdata;
  } lgc_core_state_t;
  typedef struct packed {
    logic [GS_BITS-1:0] cnt;
    logic [CH_N-1:0]    chan;
  } lgc_pwm_state_t;
endpackage
`default_nettype wire

// File: lgc_pwm_if.sv
// Carrier between the latch core and the PWM counter
`default_nettype none
interface lgc_pwm_if;
  import lgc_pkg::*;
  logic                gs_tick;
  logic                blank;
  logic                force_off;
  logic                restart;
  logic [GS_W-1:0]     gs_values;
  logic [GS_BITS-1:0]  counter;
  logic [CH_N-1:0]     chan_on;
  logic                period_end;
  modport core (output gs_tick, blank, force_off, restart, gs_values,
                input counter, chan_on, period_end);
  modport pwm  (input gs_tick, blank, force_off, restart, gs_values,
                output counter, chan_on, period_end);
endinterface
`default_nettype wire

// File: lgc_pin_sync.sv
// Two-stage pin synchroniser with rising edge detection
`default_nettype none
module lgc_pin_sync #(
  parameter int W = 6
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } lgc_sync_state_t;

  lgc_sync_state_t st_q;
  lgc_sync_state_t st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Edges seen only on the settled stages
  for (genvar i = 0; i < W; i++)
  begin : g_edge
    assign rise[i] = st_q.s2[i] & ~st_q.s3[i];
  end
  assign level = st_q.s2;
endmodule
`default_nettype wire

// File: lgc_pwm.sv
// Grayscale counter and per-channel PWM compare
`default_nettype none
module lgc_pwm
  import lgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  lgc_pwm_if.pwm   bus
);
  lgc_pwm_state_t     st_q;
  lgc_pwm_state_t     st_d;
  logic [GS_BITS-1:0] cnt_next;
  logic [CH_N-1:0]    on_next;

  // ==========================================
  // Counter
  always_comb
  begin
    if (bus.blank || bus.restart)
      cnt_next = CNT_RST;
    else if (bus.gs_tick)
      cnt_next = GS_BITS'(st_q.cnt + 1'b1);
    else
      cnt_next = st_q.cnt;
  end

  for (genvar i = 0; i < CH_N; i++)
  begin : g_chan
    assign on_next[i] = ~bus.blank & ~bus.force_off
                        & (cnt_next < bus.gs_values[i*GS_BITS +: GS_BITS]);
  end

  always_comb
  begin
    st_d      = st_q;
    st_d.cnt  = cnt_next;
    st_d.chan = on_next;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign bus.counter    = st_q.cnt;
  assign bus.chan_on    = st_q.chan;
  assign bus.period_end = bus.gs_tick & ~bus.blank & ~bus.restart & (st_q.cnt == CNT_LAST);

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  count_step_a: assert property (bus.gs_tick && !bus.blank && !bus.restart
    |=> bus.counter == GS_BITS'($past(bus.counter) + 1'b1))
    else $error("counter missed a grayscale clock edge");
  blank_off_a: assert property (bus.blank |=> bus.chan_on == CHAN_RST)
    else $error("output on while blanked");
  blank_clear_a: assert property (bus.blank[*2] |-> bus.counter == CNT_RST)
    else $error("counter not held at zero under blank");
  pwm_compare_a: assert property (!$past(bus.blank) && !$past(bus.force_off)
    |-> bus.chan_on[0] == (bus.counter < $past(bus.gs_values[GS_BITS-1:0])))
    else $error("channel zero duty wrong");
endmodule
`default_nettype wire

// File: lgc_top.sv
// LED driver latch transfer, grayscale PWM control and register port
//
// Design decisions made here: the address map and the plain strobed port.
`default_nettype none
module lgc_top
  import lgc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  serial_in,
  input  wire logic                  shift_clock,
  input  wire logic                  latch_strobe,
  input  wire logic                  grayscale_clock,
  input  wire logic                  blank,
  input  wire logic                  reference_current_pin,
  output logic                       serial_out,
  output logic      [CH_N-1:0]       channel_output,
  output logic      [CTL_KEEP_W-1:0] brightness_setting,
  output logic                       reference_short_flag,
  output logic                       irq,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DATA_W-1:0]     reg_rdata
);
  lgc_core_state_t st_q;
  lgc_core_state_t st_d;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_raw;
  logic [EV_W-1:0]  ev_set;
  logic [EV_W-1:0]  ev_clr;
  logic             sclk_rise;
  logic             lat_rise;
  logic             short_lvl;

  lgc_pwm_if pwm_bus ();

  // ==========================================
  // Pin synchronisers
  assign pin_raw = {reference_current_pin, blank, grayscale_clock, latch_strobe, shift_clock, serial_in};

  lgc_pin_sync #(
    .W (PIN_N)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (pin_raw),
    .level    (pin_lvl),
    .rise     (pin_rise)
  );

  assign sclk_rise = pin_rise[PIN_SCLK];
  assign lat_rise  = pin_rise[PIN_LAT];
  assign short_lvl = pin_lvl[PIN_SHORT];

  // ==========================================
  // PWM counter
  assign pwm_bus.gs_tick   = pin_rise[PIN_GRAYSCALE_CLOCK];
  assign pwm_bus.blank     = pin_lvl[PIN_BLANK];
  assign pwm_bus.force_off = short_lvl;
  assign pwm_bus.restart   = st_q.restart;
  assign pwm_bus.gs_values = st_q.gs2;

  lgc_pwm u_pwm (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .bus      (pwm_bus.pwm)
  );

  // ==========================================
  // Events and clears
  always_comb
  begin
    ev_set           = EV_RST;
    ev_set[EV_GS]    = lat_rise & ~st_q.shift[SR_MSB];
    ev_set[EV_CTL]   = lat_rise & st_q.shift[SR_MSB];
    ev_set[EV_SHORT] = short_lvl & ~st_q.short_flag;
    ev_clr           = EV_RST;
    if (reg_wr && reg_addr == REG_INT_CLR)
      ev_clr = reg_wdata[EV_W-1:0];
  end

  // ==========================================
  // Next state
  always_comb
  begin
    st_d         = st_q;
    st_d.restart = 1'b0;
    if (sclk_rise)
      st_d.shift = {st_q.shift[SR_W-2:0], pin_lvl[PIN_SIN]};
    if (lat_rise)
    begin
      if (st_q.shift[SR_MSB])
        st_d.ctl1 = st_q.shift[CTL_W-1:0];
      else
      begin
        st_d.gs1 = st_q.shift[GS_W-1:0];
        if (st_q.ctl1[CTL_TMR_BIT])
        begin
          st_d.gs2     = st_q.shift[GS_W-1:0];
          st_d.ctl2    = st_q.ctl1[CTL_KEEP_W-1:0];
          st_d.restart = 1'b1;
        end
      end
    end
    else if (pwm_bus.period_end)
    begin
      // Auto refresh at the end of each PWM period, except when a latch edge falls in that same cycle
      st_d.gs2  = st_q.gs1;
      st_d.ctl2 = st_q.ctl1[CTL_KEEP_W-1:0];
    end
    st_d.short_flag = short_lvl;
    // Set wins over a clear in the same cycle
    st_d.status = (st_q.status & ~ev_clr) | ev_set;
    if (reg_wr && reg_addr == REG_INT_EN)
      st_d.irq_en = reg_wdata[EV_W-1:0];
    st_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_STATUS:  st_d.rdata = DATA_W'(st_q.status);
        REG_INT_EN:  st_d.rdata = DATA_W'(st_q.irq_en);
        REG_COUNTER: st_d.rdata = DATA_W'(pwm_bus.counter);
        REG_FLAGS:   st_d.rdata = DATA_W'({st_q.ctl1[CTL_TMR_BIT], st_q.short_flag});
        default:     st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ==========================================
  // Outputs
  assign serial_out           = st_q.shift[SR_MSB];
  assign channel_output       = pwm_bus.chan_on;
  assign brightness_setting   = st_q.ctl2;
  assign reference_short_flag = st_q.short_flag;
  assign irq                  = |(st_q.status & st_q.irq_en);
  assign reg_rdata            = st_q.rdata;

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  shift_in_a: assert property (sclk_rise
    |=> st_q.shift == {$past(st_q.shift[SR_W-2:0]), $past(pin_lvl[PIN_SIN])})
    else $error("shift register did not shift");
  serial_out_a: assert property ($changed(st_q.shift[SR_MSB]) |-> $past(sclk_rise))
    else $error("serial out moved without a shift clock edge");
  gs_latch_a: assert property (lat_rise && !st_q.shift[SR_MSB]
    |=> st_q.gs1 == $past(st_q.shift[GS_W-1:0]) && $stable(st_q.ctl1))
    else $error("grayscale latch not loaded");
  ctl_latch_a: assert property (lat_rise && st_q.shift[SR_MSB]
    |=> st_q.ctl1 == $past(st_q.shift[CTL_W-1:0]) && $stable(st_q.gs1))
    else $error("control latch not loaded");
  tmr_restart_a: assert property (lat_rise && !st_q.shift[SR_MSB] && st_q.ctl1[CTL_TMR_BIT]
    |=> st_q.restart ##1 pwm_bus.counter == CNT_RST)
    else $error("timing reset did not restart counter");
  tmr_both_a: assert property (lat_rise && !st_q.shift[SR_MSB] && st_q.ctl1[CTL_TMR_BIT]
    |=> st_q.gs2 == st_q.gs1)
    else $error("grayscale stages differ after timing reset");
  tmr_ctl_copy_a: assert property (lat_rise && !st_q.shift[SR_MSB] && st_q.ctl1[CTL_TMR_BIT]
    |=> st_q.ctl2 == $past(st_q.ctl1[CTL_KEEP_W-1:0]))
    else $error("control second stage not copied");
  short_off_a: assert property (short_lvl
    |=> reference_short_flag && channel_output == CHAN_RST)
    else $error("reference short not handled");
  short_status_a: assert property (short_lvl && !st_q.short_flag
    |=> st_q.status[EV_SHORT])
    else $error("reference short event not recorded");
  status_set_a: assert property (lat_rise ##1 !lat_rise |-> st_q.status[EV_GS] || st_q.status[EV_CTL])
    else $error("latch event lost");
endmodule
`default_nettype wire

// File: lgc_ctrl_model.sv
// Display controller model: serial link, latch strobe, grayscale clock and blank
`default_nettype none
module lgc_ctrl_model
  import lgc_pkg::*;
(
  input  wire logic core_clk,
  output logic      serial_in,
  output logic      shift_clock,
  output logic      latch_strobe,
  output logic      grayscale_clock,
  output logic      blank
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    serial_in = 1'b0;
    shift_clock = 1'b0;
    latch_strobe = 1'b0;
    grayscale_clock = 1'b0;
    blank = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Link clock of 8 core cycles, still between frames
  task automatic send_frame(input logic [SR_W-1:0] v);
    for (int i = SR_MSB; i >= 0; i--)
    begin
      @(posedge core_clk);
      shift_clock <= 1'b0;
      serial_in <= v[i];
      tick(4);
      shift_clock <= 1'b1;
      tick(3);
    end
    @(posedge core_clk);
    shift_clock <= 1'b0;
    serial_in <= ~v[0];
    tick(4);
    @(negedge core_clk);
  endtask
  task automatic pulse_latch;
    @(posedge core_clk);
    latch_strobe <= 1'b1;
    tick(4);
    latch_strobe <= 1'b0;
    tick(8);
    @(negedge core_clk);
  endtask
  task automatic pulse_gs(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      grayscale_clock <= 1'b1;
      tick(4);
      grayscale_clock <= 1'b0;
      tick(3);
    end
    tick(4);
    @(negedge core_clk);
  endtask
  task automatic set_blank(input logic b);
    @(posedge core_clk);
    blank <= b;
    tick(6);
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the LED grayscale latch and PWM control block
`default_nettype none
module tb
  import lgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk, rst_b, reference_current_pin, reg_wr, reg_rd;
  logic                  serial_in, shift_clock, latch_strobe, grayscale_clock, blank;
  logic                  serial_out, reference_short_flag, irq;
  logic [CH_N-1:0]       channel_output;
  logic [CTL_KEEP_W-1:0] brightness_setting;
  logic [ADDR_W-1:0]     reg_addr;
  logic [DATA_W-1:0]     reg_wdata, reg_rdata;
  int                    miscompares, samples_checked, cycles;
  localparam logic [CTL_KEEP_W-1:0] CTL_SET   = {7'h2A, {14{8'hA5}}};
  localparam logic [SR_W-1:0]       CTL_FRAME = {1'b1, 136'h0, 1'b1, CTL_SET};
  lgc_top dut (
    .core_clk(core_clk), .rst_b(rst_b), .serial_in(serial_in), .shift_clock(shift_clock),
    .latch_strobe(latch_strobe), .grayscale_clock(grayscale_clock), .blank(blank),
    .reference_current_pin(reference_current_pin), .serial_out(serial_out),
    .channel_output(channel_output), .brightness_setting(brightness_setting),
    .reference_short_flag(reference_short_flag), .irq(irq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  lgc_ctrl_model ctl (
    .core_clk(core_clk), .serial_in(serial_in), .shift_clock(shift_clock),
    .latch_strobe(latch_strobe), .grayscale_clock(grayscale_clock), .blank(blank)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic complete_run;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end
  task automatic check_bits(input string what, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check_bits(what, exp, reg_rdata);
  endtask
  task automatic set_short(input logic s);
    @(posedge core_clk);
    reference_current_pin <= s;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  function automatic logic [SR_W-1:0] gs_frame(input logic rev);
    logic [SR_W-1:0] v;
    v = '0;
    for (int i = 0; i < CH_N; i++)
      v[16*i +: 16] = rev ? 16'(15 - i) : 16'(i);
    return v;
  endfunction
  task automatic t_reset;
    check_bits("outputs", 18'h0, {channel_output, irq, serial_out});
    check_reg("status", REG_STATUS, 32'h0);
    check_reg("counter", REG_COUNTER, 32'h0);
    check_reg("unmapped", 8'h20, 32'h0);
  endtask
  task automatic t_control;
    reg_write(REG_INT_EN, 32'h7);
    ctl.send_frame(CTL_FRAME);
    check_bits("serial_out", 1'h1, serial_out);
    ctl.pulse_latch();
    check_reg("flags", REG_FLAGS, 32'h2);
    check_reg("status", REG_STATUS, 32'h2);
    check_bits("irq", 1'h1, irq);
    check_bits("brightness", 119'h0, brightness_setting);
    reg_write(REG_INT_CLR, 32'h2);
    check_bits("irq", 1'h0, irq);
  endtask
  task automatic t_grayscale;
    ctl.send_frame(gs_frame(1'b0));
    check_bits("serial_out", 1'h0, serial_out);
    ctl.pulse_latch();
    check_reg("status", REG_STATUS, 32'h1);
    check_bits("brightness", CTL_SET, brightness_setting);
    check_bits("blanked", 16'h0, channel_output);
    ctl.set_blank(1'b0);
    check_bits("channels", 16'hFFFE, channel_output);
    ctl.pulse_gs(5);
    check_reg("counter", REG_COUNTER, 32'h5);
    check_bits("channels", 16'hFFC0, channel_output);
    ctl.send_frame(gs_frame(1'b1));
    ctl.pulse_latch();
    check_reg("counter", REG_COUNTER, 32'h0);
    check_bits("channels", 16'h7FFF, channel_output);
  endtask
  task automatic t_blank;
    ctl.pulse_gs(3);
    check_bits("channels", 16'h0FFF, channel_output);
    ctl.set_blank(1'b1);
    check_bits("blanked", 16'h0, channel_output);
    ctl.pulse_gs(2);
    check_reg("counter", REG_COUNTER, 32'h0);
    ctl.set_blank(1'b0);
    check_bits("channels", 16'h7FFF, channel_output);
  endtask
  task automatic t_short;
    reg_write(REG_INT_CLR, 32'h7);
    reg_write(REG_INT_EN, 32'h4);
    check_reg("int_en", REG_INT_EN, 32'h4);
    check_bits("irq", 1'h0, irq);
    set_short(1'b1);
    check_bits("shorted", 17'h10000, {reference_short_flag, channel_output});
    check_reg("flags", REG_FLAGS, 32'h3);
    check_bits("irq", 1'h1, irq);
    reg_write(REG_STATUS, 32'h0);
    check_reg("status", REG_STATUS, 32'h4);
    reg_write(REG_INT_EN, 32'h0);
    check_bits("irq", 1'h0, irq);
    set_short(1'b0);
    check_bits("restored", 17'h07FFF, {reference_short_flag, channel_output});
    reg_write(REG_INT_CLR, 32'h4);
    check_reg("status", REG_STATUS, 32'h0);
    check_reg("int_clr", REG_INT_CLR, 32'h0);
  endtask
  task automatic t_rerun;
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check_bits("rerun outputs", 18'h0, {channel_output, irq, serial_out});
    check_bits("rerun brightness", 119'h0, brightness_setting);
    check_reg("rerun flags", REG_FLAGS, 32'h0);
    ctl.pulse_gs(2);
    ctl.send_frame(gs_frame(1'b0));
    ctl.pulse_latch();
    check_reg("status", REG_STATUS, 32'h1);
    check_reg("counter", REG_COUNTER, 32'h2);
    check_bits("channels", 16'h0, channel_output);
    check_bits("brightness", 119'h0, brightness_setting);
  endtask
  initial
  begin
    rst_b = 1'b0;
    reference_current_pin = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_control();
    t_grayscale();
    t_blank();
    t_short();
    t_rerun();
    complete_run();
  end
endmodule
`default_nettype wire
